//--- src/fps_defs.svh
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH
// What this block does
// - Host reads status byte twice first
// - Equal toggle bits mean operation done
// - Still toggling: recheck, then check limit flag
// - Recheck toggling with limit flag set means fail; send reset
// - Leaving polling restarts from first step
// - Host checks completion before limit flag
`define FPS_REG_CTRL 2'h0
`define FPS_REG_STAT 2'h1
`define FPS_REG_ADDR 2'h2
`define FPS_REG_LAST 2'h3
`define FPS_CTRL_START 0
`define FPS_CTRL_ABORT 1
`define FPS_STAT_BUSY 0
`define FPS_STAT_DONE 1
`define FPS_STAT_FAIL 2
`define FPS_STAT_ESTART 3
`define FPS_STAT_RDY 4
`define FPS_BIT_POLL 7
`define FPS_BIT_TOGGLE 6
`define FPS_BIT_LIMIT 5
`define FPS_BIT_ESTART 3
`define FPS_BIT_STOGGLE 2
`define FPS_RESET_CMD 8'hF0
`define FPS_CLK_MHZ 20
`define FPS_T_READ_NS 100
`define FPS_T_READ_CYC ((`FPS_T_READ_NS * `FPS_CLK_MHZ + 999) / 1000)
`endif

//--- src/fps_pkg.sv
package fps_pkg;
  typedef enum logic [6:0] {
    FPS_IDLE = 7'b000_0001,
    FPS_RD1 = 7'b000_0010,
    FPS_RD2 = 7'b000_0100,
    FPS_EVAL = 7'b000_1000,
    FPS_RD3 = 7'b001_0000,
    FPS_RST = 7'b010_0000,
    FPS_FIN = 7'b100_0000
  } fps_state_t;
endpackage : fps_pkg

//--- src/fps_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fps_rd_if;
  logic req;
  logic wr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport ctl (output req, output wr, output wdata, input ack, input rdata);
  modport cyc (input req, input wr, input wdata, output ack, output rdata);
endinterface : fps_rd_if
`default_nettype wire

//--- src/fps_cycle.sv
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.svh"
module fps_cycle #(
  parameter int CYC = `FPS_T_READ_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  fps_rd_if.cyc bus,
  input wire logic [7:0] i_dq,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [7:0] o_dq,
  output logic o_dq_oe
);
  initial begin
    if (CYC < 1 || CYC > 255) $error("fps_cycle: CYC out of range");
  end
  logic [7:0] cnt_ff;
  logic act_ff;
  logic wr_ff;
  logic [7:0] rdata_ff;
  logic ack_ff;
  wire last = act_ff && (cnt_ff == 8'(CYC - 1));
  // One strobe low period per request, so each read is a distinct device read cycle.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      act_ff <= 1'b0;
      cnt_ff <= 8'h00;
      wr_ff <= 1'b0;
      o_dq <= 8'h00;
    end else if (bus.req && !act_ff) begin
      act_ff <= 1'b1;
      cnt_ff <= 8'h00;
      wr_ff <= bus.wr;
      o_dq <= bus.wdata;
    end else if (last) begin
      act_ff <= 1'b0;
    end else if (act_ff) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ack_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      ack_ff <= last;
      if (last && !wr_ff) rdata_ff <= i_dq;
    end
  end
  assign o_ce_n = !act_ff;
  assign o_oe_n = !(act_ff && !wr_ff);
  assign o_we_n = !(act_ff && wr_ff);
  assign o_dq_oe = act_ff && wr_ff;
  assign bus.ack = ack_ff;
  assign bus.rdata = rdata_ff;
endmodule : fps_cycle
`default_nettype wire

//--- src/fps_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.svh"
module fps_host (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [7:0] o_dq,
  output logic o_dq_oe,
  input wire logic [7:0] i_dq,
  input wire logic i_ready_busy_n
);
  fps_rd_if rd ();
  logic ce_n, oe_n, we_n, dq_oe;
  logic [7:0] dq;
  fps_cycle #(.CYC(`FPS_T_READ_CYC)) u_cyc (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .bus(rd.cyc),
    .i_dq(i_dq),
    .o_ce_n(ce_n),
    .o_oe_n(oe_n),
    .o_we_n(we_n),
    .o_dq(dq),
    .o_dq_oe(dq_oe)
  );
  fps_pkg::fps_state_t state_ff, nxt_state;
  logic req_ff, nxt_req;
  logic wr_ff, nxt_wr;
  logic [7:0] first_ff, nxt_first;
  logic [7:0] last_ff, nxt_last;
  logic busy_ff, done_ff, fail_ff, estart_ff;
  logic [7:0] addr_ff;
  logic [31:0] rdata_ff;
  logic rdy_ff;
  logic abort_pend_ff;
  wire start = i_wr && i_addr == `FPS_REG_CTRL && i_wdata[`FPS_CTRL_START];
  wire abort_wr = i_wr && i_addr == `FPS_REG_CTRL && i_wdata[`FPS_CTRL_ABORT];
  // The abort pulse is kept until the poll loop can act on it, since a read may be in flight.
  wire abort = abort_wr || abort_pend_ff;
  wire ack = rd.ack;
  wire [7:0] data = rd.rdata;
  wire toggled = data[`FPS_BIT_TOGGLE] != last_ff[`FPS_BIT_TOGGLE];
  wire limit = data[`FPS_BIT_LIMIT];
  wire [31:0] stat = {27'h000_0000, rdy_ff, estart_ff, fail_ff, done_ff, busy_ff};
  wire [31:0] rd_mux = (i_addr == `FPS_REG_STAT) ? stat :
                       (i_addr == `FPS_REG_ADDR) ? {24'h00_0000, addr_ff} :
                       (i_addr == `FPS_REG_LAST) ? {24'h00_0000, last_ff} : 32'h0000_0000;
  assign rd.req = req_ff;
  assign rd.wr = wr_ff;
  assign rd.wdata = `FPS_RESET_CMD;
  always_comb begin
    nxt_state = state_ff;
    nxt_req = 1'b0;
    nxt_wr = 1'b0;
    nxt_first = first_ff;
    nxt_last = last_ff;
    case (state_ff)
      fps_pkg::FPS_IDLE: begin
        if (start) begin
          nxt_state = fps_pkg::FPS_RD1;
          nxt_req = 1'b1;
        end
      end
      fps_pkg::FPS_RD1: begin
        if (ack) begin
          nxt_first = data;
          nxt_state = fps_pkg::FPS_RD2;
          nxt_req = 1'b1;
        end
      end
      fps_pkg::FPS_RD2: begin
        if (ack) begin
          nxt_last = data;
          nxt_state = fps_pkg::FPS_EVAL;
        end
      end
      fps_pkg::FPS_EVAL: begin
        if (first_ff[`FPS_BIT_TOGGLE] == last_ff[`FPS_BIT_TOGGLE]) begin
          nxt_state = fps_pkg::FPS_FIN;
        end else if (abort) begin
          nxt_state = fps_pkg::FPS_IDLE;
        end else begin
          nxt_first = last_ff;
          nxt_state = fps_pkg::FPS_RD3;
          nxt_req = 1'b1;
        end
      end
      fps_pkg::FPS_RD3: begin
        if (ack) begin
          nxt_last = data;
          if (!toggled) begin
            nxt_state = fps_pkg::FPS_FIN;
          end else if (last_ff[`FPS_BIT_LIMIT] || limit) begin
            nxt_state = fps_pkg::FPS_RST;
            nxt_req = 1'b1;
            nxt_wr = 1'b1;
          end else if (abort) begin
            nxt_state = fps_pkg::FPS_IDLE;
          end else begin
            nxt_req = 1'b1;
          end
        end
      end
      fps_pkg::FPS_RST: begin
        if (ack) nxt_state = fps_pkg::FPS_FIN;
      end
      fps_pkg::FPS_FIN: nxt_state = fps_pkg::FPS_IDLE;
      default: nxt_state = fps_pkg::FPS_IDLE;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_ff <= fps_pkg::FPS_IDLE;
      req_ff <= 1'b0;
      wr_ff <= 1'b0;
      first_ff <= 8'h00;
      last_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      req_ff <= nxt_req;
      wr_ff <= nxt_wr;
      first_ff <= nxt_first;
      last_ff <= nxt_last;
    end
  end
  // Status flags; a new start clears done and fail.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      estart_ff <= 1'b0;
      addr_ff <= 8'h00;
      rdy_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      abort_pend_ff <= 1'b0;
    end else begin
      if (state_ff == fps_pkg::FPS_IDLE) begin
        abort_pend_ff <= 1'b0;
      end else if (abort_wr) begin
        abort_pend_ff <= 1'b1;
      end
      busy_ff <= nxt_state != fps_pkg::FPS_IDLE;
      rdy_ff <= i_ready_busy_n;
      if (i_wr && i_addr == `FPS_REG_ADDR) addr_ff <= i_wdata[7:0];
      if (state_ff == fps_pkg::FPS_FIN) begin
        done_ff <= 1'b1;
      end else if (start) begin
        done_ff <= 1'b0;
      end
      if (state_ff == fps_pkg::FPS_RST) begin
        fail_ff <= 1'b1;
      end else if (start) begin
        fail_ff <= 1'b0;
      end
      if (ack && !wr_ff) estart_ff <= data[`FPS_BIT_ESTART];
      rdata_ff <= i_rd ? rd_mux : 32'h0000_0000;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_dq <= 8'h00;
      o_dq_oe <= 1'b0;
    end else begin
      o_ce_n <= ce_n;
      o_oe_n <= oe_n;
      o_we_n <= we_n;
      o_dq <= dq;
      o_dq_oe <= dq_oe;
    end
  end
  assign o_rdata = rdata_ff;
endmodule : fps_host
`default_nettype wire

//--- verif/fps_host_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fps_host_chk (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic o_ce_n,
  input wire logic o_oe_n,
  input wire logic o_we_n,
  input wire logic [7:0] o_dq,
  input wire logic o_dq_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [3:0] n_rd_ff;
  always_ff @(posedge i_clk) begin
    if (i_reset || (i_wr && i_addr == 2'h0 && i_wdata[0])) n_rd_ff <= 4'h0;
    else if ($fell(o_oe_n) && n_rd_ff != 4'hf) n_rd_ff <= n_rd_ff + 4'h1;
  end
  property p_three_rd;
    $fell(o_we_n) |-> n_rd_ff >= 4'h3;
  endproperty
  a_three_rd: assert property (p_three_rd) else $error("reset command too early");
  property p_rst_cmd;
    !o_we_n |-> o_dq_oe && o_dq == 8'hf0 && !o_ce_n;
  endproperty
  a_rst_cmd: assert property (p_rst_cmd) else $error("bad reset command");
  property p_we_len;
    $fell(o_we_n) |-> !o_we_n ##1 !o_we_n ##1 o_we_n;
  endproperty
  a_we_len: assert property (p_we_len) else $error("write pulse length");
  property p_rd_len;
    $fell(o_oe_n) |-> !o_oe_n ##1 !o_oe_n ##1 $rose(o_oe_n);
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read cycle length");
  property p_oe_ce;
    !o_oe_n |-> !o_ce_n && o_we_n && !o_dq_oe;
  endproperty
  a_oe_ce: assert property (p_oe_ce) else $error("read cycle qualifiers");
  property p_no_early;
    $rose(o_dq_oe) |-> n_rd_ff > 4'h1;
  endproperty
  a_no_early: assert property (p_no_early) else $error("drive before two reads");
  c_rst: cover property ($fell(o_we_n));
  c_rd: cover property ($fell(o_oe_n) ##4 $fell(o_oe_n));
  c_abort: cover property (i_wr && i_wdata[1]);
endmodule : fps_host_chk
bind fps_host fps_host_chk u_chk (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .o_ce_n,
  .o_oe_n, .o_we_n, .o_dq, .o_dq_oe);
`default_nettype wire

//--- verif/fps_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fps_flash_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [7:0] i_left,
  input wire logic i_fail,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_ready_busy_n
);
  logic tog_ff = 1'b0;
  logic oe_ff = 1'b1;
  logic fl_ff = 1'b0;
  logic est_ff = 1'b0;
  logic [7:0] left_ff = 8'h00;
  wire logic busy = (left_ff != 8'h00) || fl_ff;
  // status byte, array data when idle
  wire logic [7:0] st = busy ? {1'b0, tog_ff, fl_ff, 1'b0, est_ff, tog_ff, 2'b01} : 8'ha5;
  always_ff @(posedge i_clk) begin
    oe_ff <= i_oe_n;
    if (i_go) begin
      left_ff <= i_left;
      fl_ff <= i_fail;
      est_ff <= 1'b0;
    end else if (oe_ff && !i_oe_n && !i_ce_n) begin
      tog_ff <= tog_ff ^ busy;
      est_ff <= 1'b1;
      if (left_ff != 8'h00) left_ff <= left_ff - 8'h01;
    end
    if (!i_we_n && i_dq == 8'hf0) fl_ff <= 1'b0;
  end
  // Released bus shows the inverse so a stale value never passes.
  assign o_dq = (i_oe_n || i_ce_n) ? ~st : st;
  assign o_ready_busy_n = !busy;
endmodule : fps_flash_model
`default_nettype wire

//--- verif/tb_fps_host.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fps_host;
  logic i_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0, go = 1'b0, fl = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [31:0] i_wdata = 32'h0000_0000, o_rdata, rd_v;
  logic [7:0] left = 8'h00, i_dq, o_dq;
  logic o_ce_n, o_oe_n, o_we_n, rb_n;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  initial forever #25 i_clk = ~i_clk;
  fps_host uut (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_ce_n,
    .o_oe_n, .o_we_n, .o_dq, .o_dq_oe(), .i_dq, .i_ready_busy_n(rb_n));
  fps_flash_model u_mem (.i_clk, .i_go(go), .i_left(left), .i_fail(fl), .i_ce_n(o_ce_n),
    .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_dq(o_dq), .o_dq(i_dq), .o_ready_busy_n(rb_n));
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rd_v = o_rdata;
    @(posedge i_clk);
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic start(input logic [7:0] n, input logic f);
    left <= n;
    fl <= f;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    wr(2'h0, 32'h0000_0001);
  endtask : start
  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    for (int k = 0; k < 400; k++) begin
      rd(2'h1);
      if ((rd_v & m) === e) break;
    end
    chk(rd_v & m, e);
  endtask : poll
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    wr(2'h2, 32'h1234_5678);
    rd(2'h2);
    chk(rd_v, 32'h0000_0078);
    // Done at once, then after two runs of toggling reads.
    for (int n = 0; n < 12; n += 5) begin
      start(n[7:0], 1'b0);
      poll(32'h0000_0017, 32'h0000_0012);
      rd(2'h3);
      chk(rd_v & 32'h0000_00ff, 32'h0000_00a5);
    end
    start(8'h00, 1'b1);
    poll(32'h0000_0017, 32'h0000_0016);
    start(8'hff, 1'b0);
    repeat (20) @(posedge i_clk);
    wr(2'h0, 32'h0000_0002);
    poll(32'h0000_0007, 32'h0000_0000);
    start(8'h02, 1'b0);
    poll(32'h0000_0017, 32'h0000_0012);
    test_done();
  end
endmodule : tb_fps_host
`default_nettype wire
